// [verilog/sdli_top.sv]
// serial dac load interface: shift register, latch, clear, handoff to system clock
`timescale 1ns/1ns
module sdli_top #(
  parameter int RESOLUTION = 16,
  parameter bit BIPOLAR = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic async_clear_n_i,
  output logic [15:0] dac_code_o,
  output logic code_valid_o,
  input wire logic code_ready_i,
  output logic [15:0] code_data_o,
  output logic overrun_o
);
  // clear value per variant
  localparam logic [15:0] CLEAR_CODE = BIPOLAR ? sdli_pkg::MID_CODE : sdli_pkg::ZERO_CODE;
  // keep only the top resolution bits of the latched word
  localparam logic [15:0] RES_MASK = 16'hFFFF << (sdli_pkg::WORD_BITS - RESOLUTION);

  // link domain: shift register on serial clock, bit counter reset by chip select high
  logic [15:0] shift_reg;
  logic [15:0] next_shift_reg;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  always_comb begin
    next_shift_reg = {shift_reg[14:0], din_i};
    next_bit_cnt = bit_cnt;
    if (bit_cnt != sdli_pkg::BIT_CNT_FULL) begin
      next_bit_cnt = bit_cnt + 5'h01;
    end
  end
  // chip select high holds the bit counter in reset, ignoring the clock
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt <= 5'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end
  always_ff @(posedge sclk_i) begin
    if (!cs_n_i) begin
      shift_reg <= next_shift_reg;
    end
  end

  // dac latch: loaded by chip select rising, cleared asynchronously
  logic [15:0] dac_latch;
  logic full_frame;
  always_ff @(posedge cs_n_i or negedge async_clear_n_i) begin
    if (!async_clear_n_i) begin
      dac_latch <= CLEAR_CODE;
    end else begin
      dac_latch <= shift_reg & RES_MASK;
    end
  end
  always_ff @(posedge cs_n_i) begin
    full_frame <= (bit_cnt == sdli_pkg::BIT_CNT_FULL);
  end
  assign dac_code_o = dac_latch;

  // system domain: a synchronised chip select rise marks a loaded word
  logic cs_level;
  logic cs_rise;
  logic armed;
  logic next_armed;
  logic tog_event;
  sdli_sync u_cs_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(cs_n_i),
    .level_o(cs_level),
    .rise_o(cs_rise)
  );
  always_comb begin
    // the rise seen as the synchroniser leaves reset is not a frame
    tog_event = cs_rise && armed;
    next_armed = armed | cs_level;
  end
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      armed <= 1'b0;
    end else begin
      armed <= next_armed;
    end
  end

  // capture stable latch word once chip select stays high
  sdli_pkg::sdli_state_t state;
  sdli_pkg::sdli_state_t next_state;
  logic [15:0] cap_word;
  logic [15:0] next_cap_word;
  logic buf_in_ready;
  logic buf_in_valid;
  logic ovr;
  logic next_ovr;
  always_comb begin
    next_state = state;
    next_cap_word = cap_word;
    next_ovr = ovr;
    buf_in_valid = 1'b0;
    case (state)
      sdli_pkg::SDLI_IDLE: begin
        if (tog_event) begin
          next_cap_word = dac_latch;
          next_state = sdli_pkg::SDLI_OFFER;
        end
      end
      sdli_pkg::SDLI_OFFER: begin
        buf_in_valid = 1'b1;
        if (buf_in_ready) begin
          next_state = sdli_pkg::SDLI_IDLE;
        end else begin
          next_state = sdli_pkg::SDLI_HOLD;
        end
      end
      sdli_pkg::SDLI_HOLD: begin
        buf_in_valid = 1'b1;
        if (tog_event) begin
          next_ovr = 1'b1;
        end
        if (buf_in_ready) begin
          next_state = sdli_pkg::SDLI_IDLE;
        end
      end
      default: begin
        next_state = sdli_pkg::SDLI_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state <= sdli_pkg::SDLI_IDLE;
      cap_word <= 16'h0000;
      ovr <= 1'b0;
    end else begin
      state <= next_state;
      cap_word <= next_cap_word;
      ovr <= next_ovr;
    end
  end
  assign overrun_o = ovr;

  sdli_buf u_buf (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(cap_word),
    .out_valid_o(code_valid_o),
    .out_ready_i(code_ready_i),
    .out_data_o(code_data_o)
  );

  // link-domain and system-domain checks
  chk_shift_msb_first: assert property (@(posedge sclk_i) !cs_n_i && !$past(cs_n_i) |->
    shift_reg[0] == $past(din_i)) else $error("shift lsb not last din");
  chk_shift_path_moves: assert property (@(posedge sclk_i) !cs_n_i && !$past(cs_n_i) |->
    shift_reg[15:1] == $past(shift_reg[14:0])) else $error("shift not toward msb");
  chk_count_saturates: assert property (@(posedge sclk_i) !cs_n_i |-> bit_cnt <= sdli_pkg::BIT_CNT_FULL)
    else $error("bit count beyond sixteen");
  chk_latch_masked: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (dac_latch & ~RES_MASK) == 16'h0000 || dac_latch == CLEAR_CODE)
    else $error("latch low bits not masked");
  chk_clear_value: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !async_clear_n_i |-> dac_latch == CLEAR_CODE) else $error("clear value wrong");
  chk_clear_mid: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !async_clear_n_i && BIPOLAR |-> dac_latch == sdli_pkg::MID_CODE) else $error("bipolar clear not midscale");
  chk_overrun_sticky: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ovr |=> ovr) else $error("overrun flag dropped");
  chk_hold_keeps_word: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state == sdli_pkg::SDLI_HOLD |=> $stable(cap_word)) else $error("staged word changed");
  chk_event_offers: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    tog_event && state == sdli_pkg::SDLI_IDLE |=> state == sdli_pkg::SDLI_OFFER && cap_word == dac_latch)
    else $error("loaded word not staged");
  chk_latch_stable_low: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !cs_level && $stable(cs_level) && async_clear_n_i && $past(async_clear_n_i) |-> $stable(dac_latch))
    else $error("latch moved while selected");
  chk_offer_bounded: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state == sdli_pkg::SDLI_OFFER |=> state != sdli_pkg::SDLI_OFFER) else $error("offer stuck");
  chk_out_word_held: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    code_valid_o && !code_ready_i |=> code_valid_o && $stable(code_data_o)) else $error("word dropped");
  cov_frame_loaded: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) tog_event);
  cov_buf_full: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) !buf_in_ready);
  cov_overrun: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(ovr));
  cov_full_frame: cover property (@(posedge sclk_i) full_frame);
endmodule : sdli_top

// [verilog/sdli_pkg.sv]
// constants and shared definitions for the serial dac load interface
// Functional notes
// - shift only while chip select is low
// - chip select rising latches word, updates output
// - data sampled on serial clock rising edge
// - unipolar clear forces latch to zero
// - bipolar clear forces latch to midscale
// - latch resolution 16, 14 or 12 bits
// - three host-driven wires, no readback
// - data shifted most significant bit first
// - only last sixteen bits are transferred
// - short codes left-justified, trailing don't-cares
// - bipolar midscale 32768, 8192 or 2048
package sdli_pkg;
  localparam int WORD_BITS = 16;
  localparam int RES_16 = 16;
  localparam int RES_14 = 14;
  localparam int RES_12 = 12;
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam int POWER_UP_US = 30;
  localparam int SYNC_STAGES = 3;
  localparam logic [4:0] BIT_CNT_FULL = 5'h10;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  typedef enum logic [1:0] {
    SDLI_IDLE = 2'b00,
    SDLI_OFFER = 2'b01,
    SDLI_HOLD = 2'b11
  } sdli_state_t;
endpackage : sdli_pkg

// [verilog/sdli_sync.sv]
// three-stage level synchroniser into the system clock
`timescale 1ns/1ns
module sdli_sync (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;
  always_comb begin
    next_level = level_o;
    if (s2 == s3) begin
      next_level = s2;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      level_o <= next_level;
    end
  end
  assign rise_o = next_level & ~level_o;
endmodule : sdli_sync

// [verilog/sdli_buf.sv]
// two-entry valid/ready buffer for latched codes
`timescale 1ns/1ns
module sdli_buf (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [15:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [15:0] out_data_o
);
  logic [15:0] mem [0:1];
  logic [1:0] count;
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] next_count;
  logic next_rd_ptr;
  logic next_wr_ptr;
  logic push;
  logic pop;
  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_count = count;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    if (push) begin
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      count <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      count <= next_count;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  assign in_ready_o = (count != sdli_pkg::BUF_DEPTH);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = mem[rd_ptr];
endmodule : sdli_buf

// [tb/sdli_host.sv]
// host serial controller model driving chip select, serial clock and data
`timescale 1ns/1ns
module sdli_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  logic run = 1'b0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // data pattern changes every link cycle between frames
  always #12 if (!run) din_o = ~din_o;
  task automatic frame(input logic [31:0] word, input int n);
    run = 1'b1;
    cs_n_o = 1'b0;
    din_o = word[n - 1];
    #12;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b1;
      #1;
      if (i > 0) din_o = word[i - 1];
      #5 sclk_o = 1'b0;
      #6;
    end
    cs_n_o = 1'b1;
    #8 run = 1'b0;
  endtask : frame
  task automatic stray(input int n);
    repeat (n) begin
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
  endtask : stray
endmodule : sdli_host

// [tb/test_serial_dac_load_interface.sv]
// testbench for the serial dac load interface
`timescale 1ns/1ns
module test_serial_dac_load_interface;
  localparam int RES = sdli_pkg::RES_14;
  localparam logic [15:0] MASK = ~((16'h0001 << (16 - RES)) - 16'h0001);
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clear_n = 1'b1;
  logic ready = 1'b0;
  logic stall = 1'b0;
  logic loose = 1'b0;
  logic take_now;
  logic sclk, cs_n, din, code_valid, overrun;
  logic [15:0] dac_code, code_data, last;
  logic [15:0] exp_q[$];
  int mismatches = 0;
  int check_count = 0;
  always #50 ref_clk = ~ref_clk;
  sdli_host host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
  sdli_top #(.RESOLUTION(RES), .BIPOLAR(1'b1)) dut (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .async_clear_n_i(clear_n), .dac_code_o(dac_code),
    .code_valid_o(code_valid), .code_ready_i(ready), .code_data_o(code_data),
    .overrun_o(overrun)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic send(input logic [31:0] word, input int n);
    host.frame(word, n);
    last = word[15:0] & MASK;
    exp_q.push_back(last);
    #1 check(dac_code, last);
    repeat (8) @(negedge ref_clk);
  endtask : send
  // stream model: a word offered with ready raised is taken at the next rising edge
  always @(negedge ref_clk) begin
    take_now = stall ? 1'b0 : 1'($urandom % 2);
    if (reset_n && code_valid === 1'b1 && take_now) begin
      if (exp_q.size() > 0)
        check(code_data, exp_q.pop_front());
      else if (!loose)
        check(code_data, 16'hXXXX);
    end
    ready <= take_now;
  end
  initial begin
    #1_000_000;
    mismatches++;
    wrap_up();
  end
  initial begin
    void'($urandom(27603));
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    check(16'(code_valid), 16'h0000);
    check(16'(overrun), 16'h0000);
    clear_n = 1'b0;
    #1 check(dac_code, 16'h8000);
    @(negedge ref_clk);
    clear_n = 1'b1;
    #(sdli_pkg::POWER_UP_US * 1000);
    @(negedge ref_clk);
    repeat (8) send($urandom, 16);
    host.stray(5);
    #1 check(dac_code, last);
    repeat (8) @(negedge ref_clk);
    send($urandom, 20);
    clear_n = 1'b0;
    #1 check(dac_code, 16'h8000);
    @(negedge ref_clk);
    clear_n = 1'b1;
    repeat (20) @(negedge ref_clk);
    wait (exp_q.size() == 0);
    @(negedge ref_clk);
    stall = 1'b1;
    loose = 1'b1;
    repeat (4) send($urandom, 16);
    check(16'(overrun), 16'h0001);
    // two buffer entries plus the staged word survive, the fourth is lost
    while (exp_q.size() > 3) void'(exp_q.pop_back());
    stall = 1'b0;
    repeat (30) @(negedge ref_clk);
    loose = 1'b0;
    check(16'(exp_q.size()), 16'h0000);
    wrap_up();
  end
endmodule : test_serial_dac_load_interface
